// >>> verif/cdjb_demod_model.sv
// Purpose: Symbol source that stands in for the demodulator side.
// Assumes: Each clock with req high asks for one more whole frame of 32 symbols.
// Notes:   While bad is high, symbols 3 and 5 of every frame arrive damaged.
`timescale 1ns/1ps
`default_nettype none
module cdjb_demod_model (
  // Clock.
  input  wire logic       clk,
  // Control from the bench.
  input  wire logic       req,
  input  wire logic       bad,
  // Symbol stream.
  output logic            sym_valid,
  output logic [7:0]      sym_data,
  output logic            sym_frame_start,
  input  wire logic       sym_ready
);
  int pend = 0;
  int idx  = 0;

  initial begin
    sym_valid       = 1'b0;
    sym_data        = 8'h00;
    sym_frame_start = 1'b0;
  end

  // The symbol index only moves on an accepted symbol, so an offer holds until taken.
  always @(posedge clk) begin
    if (sym_valid && sym_ready) begin
      idx = (idx + 1) % 32;
      if (idx == 0) pend = pend - 1;
    end
    if (req) pend = pend + 1;
  end

  // Between frames the data line stays driven and is inverted on every falling edge.
  always @(negedge clk) begin
    sym_valid       <= (pend > 0);
    sym_frame_start <= (pend > 0) && (idx == 0);
    if (pend == 0) sym_data <= ~sym_data;
    else if (bad && idx == 3) sym_data <= 8'h55;
    else if (bad && idx == 5) sym_data <= 8'hAA;
    else sym_data <= 8'h5A;
  end
endmodule : cdjb_demod_model
`default_nettype wire

// >>> verif/testbench.sv
// Purpose: Self-checking bench for the jitter buffer, servo divisor and flags.
// Assumes: Frame period shortened to 160 clocks; the bench answers as decoder.
// Notes:   Flag counts are summed over 28 frames so the rotating pattern cancels.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cdjb_pkg::*;
  localparam int FC = 160;
  logic             clk, sym_valid, sym_frame_start, sym_ready, mute_q, recentre_q;
  logic             dec_sym_valid_q, dec_stage_q, dec_last_q, out_valid_q, out_flag_q;
  logic [7:0]       sym_data, dec_sym_q, out_data_q;
  logic [9:0]       clv_div_q;
  logic             resetn = 1'b0, req = 1'b0, bad = 1'b0, dec_done = 1'b0, saw_f = 1'b0;
  logic [1:0]       dec_nerr = 2'h0;
  logic [4:0]       dec_pos0 = 5'h00, dec_pos1 = 5'h00;
  logic [7:0]       dec_val0 = 8'h00, dec_val1 = 8'h00;
  logic [27:0]      vec = 28'h0000000;
  logic             stg = 1'b0, meas = 1'b0, dchk = 1'b0, c1_fix = 1'b0, c2_fix = 1'b0;
  int               fails = 0, n_compared = 0, fcount = 0, exp_sum = 0;
  int               wc = 0, fcnt = 0, k_cfg = 0, c2_n = 0, c2_m = 0;

  cdjb_core #(.FRAME_CYC(FC), .FIFO_DEPTH(32)) cdjb_core_i (
    .clk, .resetn, .sym_valid, .sym_data, .sym_frame_start, .sym_ready,
    .clv_div_q, .mute_q, .recentre_q, .dec_sym_valid_q, .dec_sym_q, .dec_stage_q,
    .dec_last_q, .dec_done, .dec_nerr, .dec_pos0, .dec_pos1, .dec_val0, .dec_val1,
    .out_valid_q, .out_data_q, .out_flag_q);

  cdjb_demod_model cdjb_demod_model_i (
    .clk, .req, .bad, .sym_valid, .sym_data, .sym_frame_start, .sym_ready);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compared=%0d failed=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic give_up;
    fails++;
    report_and_stop();
  endtask : give_up

  task automatic cmp_v(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_v

  task automatic cmp_n(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_n

  function automatic int pick(input logic [27:0] v, input logic b, input int from);
    for (int i = from; i < 28; i++) if (v[i] === b) return i;
    return 27;
  endfunction : pick

  // Expected second-stage flag count of one frame from its error case.
  function automatic int expf(input int n, input int m, input int pc);
    if (n < 2) return 0;
    if (n == 3) return (pc <= 2) ? 28 : pc;
    if (m == 2) return (pc >= 7) ? pc : 0;
    if (m == 1) return (pc <= 5) ? 28 : pc;
    return (pc <= 2) ? 28 : pc;
  endfunction : expf

  ////////////////////////////////////////////////////////////////////////////
  // Decoder stand-in: answers three cycles after the last symbol of a codeword.
  always @(negedge clk) begin
    dec_done = (wc == 1);
    if (wc == 1 && stg == 1'b0) begin
      dec_nerr = ((fcnt % 28) < k_cfg) ? 2'(2 + fcnt % 2) : (c1_fix ? 2'h1 : 2'(fcnt % 2));
      dec_pos0 = 5'h03;
      dec_pos1 = 5'h1E;
      dec_val0 = c1_fix ? 8'h0F : 8'h00;
      vec = {vec[26:0], (fcnt % 28) < k_cfg};
      fcnt++;
    end
    if (wc == 1 && stg == 1'b1) begin
      dec_nerr = 2'(c2_n);
      dec_pos0 = 5'((c2_n == 1) ? 5 : (c2_m > 0) ? pick(vec, 1'b1, 0) : pick(vec, 1'b0, 0));
      dec_pos1 = 5'((c2_m == 2) ? pick(vec, 1'b1, pick(vec, 1'b1, 0) + 1) :
                    (c2_m == 1) ? pick(vec, 1'b0, 0) : pick(vec, 1'b0, pick(vec, 1'b0, 0) + 1));
      dec_val0 = c2_fix ? 8'hF0 : 8'h00;
      if (meas) exp_sum += expf(c2_n, c2_m, $countones(vec));
    end
    if (wc > 0) wc--;
    else if (dec_last_q === 1'b1) begin
      wc = 3;
      stg = dec_stage_q;
    end
  end

  always @(negedge clk) begin
    if (recentre_q === 1'b1) saw_f = 1'b1;
    if (meas && out_valid_q === 1'b1 && out_flag_q === 1'b1) fcount++;
    if (meas && out_valid_q === 1'b1) cmp_v(16'(out_data_q), 16'h005A);
    if (dchk && out_valid_q === 1'b1) begin
      cmp_v(16'(out_data_q), 16'h005A);
      cmp_v(16'(out_flag_q), 16'h0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One frame period: wait for the first-stage stream, ask for n frames, let it finish.
  task automatic period(input int n);
    int i;
    i = 0;
    while (!(dec_sym_valid_q === 1'b1 && dec_stage_q === 1'b0)) begin
      @(negedge clk);
      i++;
      if (i > 2 * FC) give_up();
    end
    repeat (n) begin
      req = 1'b1;
      @(negedge clk);
    end
    req = 1'b0;
    repeat (120) @(negedge clk);
  endtask : period

  task automatic t_reset;
    int i;
    cmp_v(16'(clv_div_q), 16'(DIV_STD));
    cmp_v(16'(out_valid_q), 16'h0000);
    resetn = 1'b1;
    i = 0;
    while (saw_f !== 1'b1) begin
      @(negedge clk);
      i++;
      if (i > 20) give_up();
    end
    repeat (2) @(negedge clk);
    cmp_v(16'(mute_q), 16'h0001);
    saw_f = 1'b0;
    $display("test reset done");
  endtask : t_reset

  task automatic t_servo;
    int         tn[12] = '{1, 1, 2, 0, 0, 0, 0, 0, 2, 2, 2, 2};
    logic [9:0] td[12] = '{10'h000, DIV_STD, DIV_DN, DIV_STD, DIV_UP, DIV_UP, DIV_UP,
                           10'h3FF, DIV_DN, DIV_DN, DIV_DN, 10'h3FF};
    for (int p = 0; p < 12; p++) begin
      period(tn[p]);
      if (td[p] != 10'h000) begin
        cmp_v(16'(saw_f), 16'(td[p] == 10'h3FF));
        cmp_v(16'(clv_div_q), 16'((td[p] == 10'h3FF) ? DIV_STD : td[p]));
      end
      saw_f = 1'b0;
    end
    $display("test servo done");
  endtask : t_servo

  task automatic t_mute;
    int k;
    k = 0;
    while (mute_q !== 1'b0) begin
      period(1);
      k++;
      if (k > 140) give_up();
    end
    cmp_n(k, 128);
    $display("test mute done");
  endtask : t_mute

  task automatic t_data;
    k_cfg = 0;
    c2_n = 0;
    dchk = 1'b1;
    repeat (2) period(1);
    dchk = 1'b0;
    c1_fix = 1'b1;
    c2_fix = 1'b1;
    c2_n = 1;
    bad = 1'b1;
    repeat (6) period(1);
    dchk = 1'b1;
    repeat (4) period(1);
    dchk = 1'b0;
    c1_fix = 1'b0;
    c2_fix = 1'b0;
    bad = 1'b0;
    $display("test data done");
  endtask : t_data

  task automatic t_flags;
    int kk[10] = '{2, 2, 2, 2, 6, 6, 7, 7, 7, 7};
    int nn[10] = '{2, 2, 2, 3, 2, 2, 2, 2, 2, 3};
    int mm[10] = '{2, 1, 0, 0, 2, 1, 2, 1, 0, 0};
    for (int c = 0; c < 10; c++) begin
      if (c == 0 || kk[c] != kk[c - 1]) begin
        k_cfg = kk[c];
        repeat (28) period(1);
      end
      c2_n = nn[c];
      c2_m = mm[c];
      repeat (2) period(1);
      fcount = 0;
      exp_sum = 0;
      meas = 1'b1;
      repeat (28) period(1);
      meas = 1'b0;
      cmp_n(fcount, exp_sum);
    end
    $display("test flags done");
  endtask : t_flags

  initial begin
    repeat (3) @(negedge clk);
    t_reset();
    t_servo();
    t_mute();
    t_data();
    t_flags();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire

// >>> verilog/cdjb_core.sv
// Purpose: Jitter buffer, write centring, two-stage flag handling and output.
// Assumes: The decoder returns error count, positions and values per codeword.
// Notes:   Second-stage codeword covers symbols 0..27 of the frame in buffer.
`timescale 1ns/1ps
`default_nettype none
module cdjb_core
  import cdjb_pkg::*;
#(
  parameter int FRAME_CYC  = FRAME_CYC_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             resetn,
  // Demodulated symbol stream.
  input  wire logic             sym_valid,
  input  wire logic [SYM_W-1:0] sym_data,
  input  wire logic             sym_frame_start,
  output logic                  sym_ready,
  // Servo and mute.
  output logic [9:0]            clv_div_q,
  output logic                  mute_q,
  output logic                  recentre_q,
  // Symbols to the decoder.
  output logic                  dec_sym_valid_q,
  output logic [SYM_W-1:0]      dec_sym_q,
  output logic                  dec_stage_q,
  output logic                  dec_last_q,
  // Decoder result.
  input  wire logic             dec_done,
  input  wire logic [1:0]       dec_nerr,
  input  wire logic [4:0]       dec_pos0,
  input  wire logic [4:0]       dec_pos1,
  input  wire logic [SYM_W-1:0] dec_val0,
  input  wire logic [SYM_W-1:0] dec_val1,
  // Corrected audio stream.
  output logic                  out_valid_q,
  output logic [SYM_W-1:0]      out_data_q,
  output logic                  out_flag_q
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]        rs_q;
  logic              rst_n;
  cdjb_state_t       st_q;
  logic [14:0]       tick_cnt_q;
  logic              tick;
  logic [FR_W-1:0]   wr_frame_q;
  logic [SYM_AW-1:0] wr_sym_q;
  logic [FR_W-1:0]   rd_frame_q;
  logic [FR_W-1:0]   cur_fr_q;
  logic [FR_W-1:0]   diff;
  logic              force_c;
  logic [7:0]        mute_cnt_q;
  logic [SYM_W-1:0]  ram_q [RAM_WORDS];
  logic [SYM_W-1:0]  ram_rd_q;
  logic              ram_v_q;
  logic [SYM_AW-1:0] ridx_q;
  logic [SYM_W-1:0]  frame_q [32];
  logic [5:0]        idx_q;
  logic              f_valid;
  logic [SYM_W:0]    f_data;
  logic              drain;
  logic              fix_st;
  logic              fix_we;
  logic [1:0]        fix_n_q;
  logic [4:0]        fp0_q;
  logic [4:0]        fp1_q;
  logic [SYM_W-1:0]  fv0_q;
  logic [SYM_W-1:0]  fv1_q;
  logic [4:0]        fpos;
  logic [SYM_W-1:0]  fval;
  logic [C2_SYMS-1:0] c1_flags_q;
  logic [C2_SYMS-1:0] c2_flags_q;
  logic [C2_SYMS-1:0] c2_d;
  logic [31:0]       c1_pad;
  logic [31:0]       c2_pad;
  logic [4:0]        c1_cnt;
  logic              m0;
  logic              m1;
  logic              c1_flag;
  logic [1:0]        fixn1;
  logic [1:0]        fixn2;
  logic              emit;
  logic [SYM_W-1:0]  nsym;
  logic              nflag;
  logic [SYM_W-1:0]  pend_q;
  logic              pf_q;
  logic              pv_q;
  logic              pb_q;
  logic [SYM_W-1:0]  last_q;
  logic [SYM_W:0]    sum_c;
  logic [SYM_W-1:0]  sel;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rs_q <= 2'h0;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign rst_n = rs_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Write side: FIFO drains unless a correction owns the port; drained symbols go into the RAM except while force_c is high.
  cdjb_fifo #(
    .W     (SYM_W + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (sym_valid),
    .in_data   ({sym_frame_start, sym_data}),
    .in_ready  (sym_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (!fix_st)
  );
  assign fix_st = (st_q == ST_C1FIX) || (st_q == ST_C2FIX);
  assign drain  = f_valid && !fix_st;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 15'h0000;
    end else if (tick) begin
      tick_cnt_q <= 15'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end
  assign tick = tick_cnt_q == 15'(FRAME_CYC - 1);

  assign diff    = wr_frame_q - rd_frame_q;
  assign force_c = (diff <= LOW_LIM) || (diff >= HIGH_LIM);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_frame_q <= '0;
      wr_sym_q   <= '0;
      rd_frame_q <= '0;
    end else begin
      if (tick) begin
        rd_frame_q <= rd_frame_q + 1'b1;
      end
      if (force_c) begin
        wr_frame_q <= rd_frame_q + CTR_FR;
        wr_sym_q   <= '0;
      end else if (drain && f_data[SYM_W]) begin
        wr_frame_q <= wr_frame_q + 1'b1;
        wr_sym_q   <= 5'h01;
      end else if (drain) begin
        wr_sym_q <= wr_sym_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clv_div_q <= DIV_STD;
    end else if (diff == CTR_FR) begin
      clv_div_q <= DIV_STD;
    end else if (diff < CTR_FR) begin
      clv_div_q <= DIV_UP;
    end else begin
      clv_div_q <= DIV_DN;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mute_cnt_q <= 8'h00;
      mute_q     <= 1'b0;
      recentre_q <= 1'b0;
    end else begin
      recentre_q <= force_c;
      if (force_c) begin
        mute_cnt_q <= MUTE_FRAMES;
        mute_q     <= 1'b1;
      end else if (tick && mute_cnt_q != 8'h00) begin
        mute_cnt_q <= mute_cnt_q - 1'b1;
        mute_q     <= mute_cnt_q != 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // symbol RAM
  assign fix_we = fix_st && (idx_q[1:0] < fix_n_q);
  assign fpos   = idx_q[0] ? fp1_q : fp0_q;
  assign fval   = idx_q[0] ? fv1_q : fv0_q;

  always_ff @(posedge clk) begin
    if (fix_we) begin
      ram_q[{cur_fr_q, fpos}] <= frame_q[fpos] ^ fval;
    end else if (drain && !force_c) begin
      if (f_data[SYM_W]) begin
        ram_q[{wr_frame_q + 1'b1, 5'h00}] <= f_data[SYM_W-1:0];
      end else begin
        ram_q[{wr_frame_q, wr_sym_q}] <= f_data[SYM_W-1:0];
      end
    end
    ram_rd_q <= ram_q[{cur_fr_q, idx_q[4:0]}];
  end

  always_ff @(posedge clk) begin
    if (ram_v_q) begin
      frame_q[ridx_q] <= ram_rd_q;
    end else if (fix_we) begin
      frame_q[fpos] <= frame_q[fpos] ^ fval;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first- and second-stage decisions
  assign c1_flag = dec_nerr >= NERR_2;
  assign fixn1   = (dec_nerr == NERR_1 || dec_nerr == NERR_2) ? dec_nerr : 2'h0;
  assign c1_pad  = {4'h0, c1_flags_q};
  assign c2_pad  = {4'h0, c2_flags_q};
  assign c1_cnt  = 5'($countones(c1_flags_q));
  assign m0      = c1_pad[dec_pos0];
  assign m1      = c1_pad[dec_pos1];

  always_comb begin
    c2_d  = c1_flags_q;
    fixn2 = 2'h0;
    case (dec_nerr)
      NERR_0: begin
        c2_d = '0;
      end
      NERR_1: begin
        c2_d  = '0;
        fixn2 = 2'h1;
      end
      NERR_2: begin
        if (m0 && m1 && c1_cnt < TWO_MATCH_MAX) begin
          c2_d  = '0;
          fixn2 = 2'h2;
        end else if (m0 && m1) begin
          c2_d = c1_flags_q;
        end else if (m0 || m1) begin
          c2_d = (c1_cnt <= ONE_MATCH_MAX) ? '1 : c1_flags_q;
        end else begin
          c2_d = (c1_cnt <= NO_MATCH_MAX) ? '1 : c1_flags_q;
        end
      end
      default: begin
        c2_d = (c1_cnt <= NO_MATCH_MAX) ? '1 : c1_flags_q;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c1_flags_q <= '0;
      c2_flags_q <= '0;
      fix_n_q    <= 2'h0;
      fp0_q      <= 5'h00;
      fp1_q      <= 5'h00;
      fv0_q      <= 8'h00;
      fv1_q      <= 8'h00;
    end else if (dec_done && (st_q == ST_C1WT || st_q == ST_C2WT)) begin
      fp0_q <= dec_pos0;
      fp1_q <= dec_pos1;
      fv0_q <= dec_val0;
      fv1_q <= dec_val1;
      if (st_q == ST_C1WT) begin
        c1_flags_q <= {c1_flags_q[C2_SYMS-2:0], c1_flag};
        fix_n_q    <= fixn1;
      end else begin
        c2_flags_q <= c2_d;
        fix_n_q    <= fixn2;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fixed-order correction sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= ST_IDLE;
      idx_q    <= 6'h00;
      cur_fr_q <= '0;
      ram_v_q  <= 1'b0;
      ridx_q   <= '0;
    end else begin
      ram_v_q <= st_q == ST_RD;
      ridx_q  <= idx_q[4:0];
      case (st_q)
        ST_IDLE: begin
          idx_q <= 6'h00;
          if (tick) begin
            cur_fr_q <= rd_frame_q;
            st_q     <= ST_RD;
          end
        end
        ST_RD: begin
          idx_q <= idx_q + 1'b1;
          if (idx_q == LAST_SYM) begin
            st_q <= ST_C1WT;
          end
        end
        ST_C1WT, ST_C2WT: begin
          idx_q <= 6'h00;
          if (dec_done) begin
            st_q <= (st_q == ST_C1WT) ? ST_C1FIX : ST_C2FIX;
          end
        end
        ST_C1FIX, ST_C2FIX: begin
          idx_q <= idx_q + 1'b1;
          if (idx_q[1:0] == fix_n_q) begin
            idx_q <= 6'h00;
            st_q  <= (st_q == ST_C1FIX) ? ST_C2ST : ST_OUT;
          end
        end
        ST_C2ST, ST_OUT: begin
          idx_q <= idx_q + 1'b1;
          if (idx_q == LAST_C2) begin
            st_q <= (st_q == ST_C2ST) ? ST_C2WT : ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_sym_valid_q <= 1'b0;
      dec_sym_q       <= 8'h00;
      dec_stage_q     <= 1'b0;
      dec_last_q      <= 1'b0;
    end else begin
      dec_sym_valid_q <= ram_v_q || (st_q == ST_C2ST);
      dec_stage_q     <= st_q == ST_C2ST;
      dec_sym_q       <= ram_v_q ? ram_rd_q : frame_q[idx_q[4:0]];
      dec_last_q      <= ram_v_q ? (ridx_q == LAST_SYM[4:0]) : (st_q == ST_C2ST && idx_q == LAST_C2);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interpolate or hold
  assign emit  = st_q == ST_OUT;
  assign nsym  = frame_q[idx_q[4:0]];
  assign nflag = c2_pad[idx_q[4:0]];
  assign sum_c = {last_q[SYM_W-1], last_q} + {nsym[SYM_W-1], nsym};

  always_comb begin
    sel = pend_q;
    if (pf_q && (pb_q || nflag)) begin
      sel = last_q;
    end else if (pf_q) begin
      sel = sum_c[SYM_W:1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q      <= 8'h00;
      pf_q        <= 1'b0;
      pv_q        <= 1'b0;
      pb_q        <= 1'b0;
      last_q      <= 8'h00;
      out_valid_q <= 1'b0;
      out_data_q  <= 8'h00;
      out_flag_q  <= 1'b0;
    end else begin
      out_valid_q <= emit && pv_q;
      if (emit) begin
        pend_q <= nsym;
        pf_q   <= nflag;
        pv_q   <= 1'b1;
        if (pv_q) begin
          out_data_q <= mute_q ? 8'h00 : sel;
          out_flag_q <= pf_q;
          last_q     <= sel;
          pb_q       <= pf_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_div_centre: assert property (diff == CTR_FR |=> clv_div_q == DIV_STD)
    else $error("divisor not standard when centred");
  a_div_behind: assert property (diff < CTR_FR && diff > LOW_LIM |=> clv_div_q == DIV_UP)
    else $error("divisor not raised when behind");
  a_force_centre: assert property (force_c |=> wr_frame_q == $past(rd_frame_q) + CTR_FR)
    else $error("write frame not re-centred");
  a_mute_start: assert property (force_c |=> mute_q && mute_cnt_q == MUTE_FRAMES ##1 mute_q)
    else $error("mute not started for full period");
  a_mute_out: assert property (out_valid_q && $past(mute_q) |-> out_data_q == 8'h00)
    else $error("muted output not zero");
  a_c1_flag: assert property (st_q == ST_C1WT && dec_done |=> c1_flags_q[0] == ($past(dec_nerr) >= NERR_2))
    else $error("first-stage flag wrong");
  a_c2_clear: assert property (st_q == ST_C2WT && dec_done && dec_nerr <= NERR_1 |=> c2_flags_q == '0)
    else $error("second-stage flags not cleared");
  a_c2_match: assert property (st_q == ST_C2WT && dec_done && dec_nerr == NERR_2 && m0 && m1
    && c1_cnt < TWO_MATCH_MAX |=> c2_flags_q == '0 && fix_n_q == 2'h2 && fix_we ##1 fix_we)
    else $error("matched pair not corrected");
  a_c2_copy: assert property (st_q == ST_C2WT && dec_done && dec_nerr == 2'h3 && c1_cnt > NO_MATCH_MAX
    |=> c2_flags_q == $past(c1_flags_q) && fix_n_q == 2'h0)
    else $error("flags not copied on many errors");
  a_fix_port: assert property (fix_st && f_valid |=> f_valid && $stable(f_data))
    else $error("symbol lost during correction");
endmodule : cdjb_core
`default_nettype wire

// >>> verilog/cdjb_fifo.sv
// Purpose: Valid/ready FIFO between the demodulator and the buffer RAM.
// Assumes: DEPTH is a power of two.
// Notes:   in_ready is registered so the source sees it from a flip-flop.
`timescale 1ns/1ps
`default_nettype none
module cdjb_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side.
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side.
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          push;
  logic          pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rp_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q     <= '0;
      rp_q     <= '0;
      cnt_q    <= '0;
      in_ready <= 1'b1;
    end else begin
      cnt_q    <= cnt_d;
      in_ready <= cnt_d != (AW+1)'(DEPTH);
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule : cdjb_fifo
`default_nettype wire

// >>> verilog/cdjb_pkg.sv
// Purpose: Shared constants and types of the jitter buffer and flag logic.
// Assumes: One 125 MHz clock; demodulator and decoder run on the same clock.
// Notes:   Frame pointers are six bits wide over a 64-frame ring.
package cdjb_pkg;
  localparam int          SYM_W          = 8;
  localparam int          RAM_WORDS      = 2048;
  localparam int          FR_W           = 6;
  localparam int          SYM_AW         = 5;
  localparam int          C2_SYMS        = 28;
  localparam int          FIFO_DEPTH_DEF = 32;
  localparam int          CLK_MHZ        = 125;
  localparam int          FRAME_NS       = 136054;
  localparam int          FRAME_CYC_DEF  = FRAME_NS * CLK_MHZ / 1000;
  localparam logic [5:0]  CTR_FR         = 6'h04;
  localparam logic [5:0]  LOW_LIM        = 6'h00;
  localparam logic [5:0]  HIGH_LIM       = 6'h08;
  localparam logic [9:0]  DIV_STD        = 10'h24C;
  localparam logic [9:0]  DIV_UP         = 10'h24D;
  localparam logic [9:0]  DIV_DN         = 10'h24B;
  localparam logic [7:0]  MUTE_FRAMES    = 8'h80;
  localparam logic [5:0]  LAST_SYM       = 6'h1F;
  localparam logic [5:0]  LAST_C2        = 6'h1B;
  localparam logic [4:0]  TWO_MATCH_MAX  = 5'h07;
  localparam logic [4:0]  ONE_MATCH_MAX  = 5'h05;
  localparam logic [4:0]  NO_MATCH_MAX   = 5'h02;
  localparam logic [1:0]  NERR_0         = 2'h0;
  localparam logic [1:0]  NERR_1         = 2'h1;
  localparam logic [1:0]  NERR_2         = 2'h2;
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_RD    = 8'h02,
    ST_C1WT  = 8'h04,
    ST_C1FIX = 8'h08,
    ST_C2ST  = 8'h10,
    ST_C2WT  = 8'h20,
    ST_C2FIX = 8'h40,
    ST_OUT   = 8'h80
  } cdjb_state_t;
endpackage : cdjb_pkg
